// [verilog/ldr_regs.sv]
/*
 * ldr_regs: page-2 link diagnostic register bank, wire length and clock drift.
 * assumes: a management front end gives one-cycle rd/wr strobes with a 5-bit
 * register address; read data is returned one cycle after rd.
 * link status pins are asynchronous and are synchronised here.
 * signal processor values are on this clock and steady while valid is high.
 * the page selection register lives here; only bits [1:0] are kept.
 * a capture request while one is pending is dropped.
 * other registers are answered elsewhere; hit_out tells which were ours.
 */
// Operation
// - registers 14h and 15h answer only when page selection bits [1:0] hold 10.
// - reserved upper bits ignore writes and read as zero.
// - wire length is an 8-bit meter estimate in the low byte, FF meaning unknown.
// - the estimate only has meaning at 100 Mb/s with link up, else it shows FF.
// - trigger with choice zero fetches the long-term frequency offset.
// - trigger with choice one fetches the present frequency control value.
// - the trigger bit is a self-clearing strobe that always reads zero.
// - the fetched value lands in the drift register low byte after the trigger.
// - the drift byte is two's complement in steps of about 5.1562 ppm.
// - the frequency control value is the long-term offset plus phase correction.
// - every field of both registers resets to zero.
`timescale 1ns/1ps
module ldr_regs (
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  srst_in,
    // management access
    input  wire ldr_pkg::ldr_req_type  req_in,
    output logic [15:0]                rdata_out,
    output logic                       rvalid_out,
    output logic                       hit_out,
    // link and signal processor status
    input  wire ldr_pkg::ldr_link_type link_in,
    input  wire ldr_pkg::ldr_dsp_type  dsp_in,
    // capture status
    output logic                       capture_busy_out
);
    import ldr_pkg::*;

    ldr_link_type  link_meta_reg;
    ldr_link_type  link_sync_reg;
    logic [1:0]    page_reg;
    logic [1:0]    page_next;
    logic [7:0]    length_reg;
    logic [7:0]    length_next;
    logic          choice_reg;
    logic          choice_next;
    logic          trigger_reg;
    logic          trigger_next;
    logic [15:0]   rdata_reg;
    logic [15:0]   rdata_next;
    logic          rvalid_reg;
    logic          rvalid_next;
    logic          hit_reg;
    logic          hit_next;
    logic          busy_reg;
    logic          busy_next;
    ldr_link_type  link_hold_reg;
    logic          link_stable;
    logic [7:0]    drift_value;
    logic          sampler_busy;
    logic          diag_page;

    function automatic logic ldr_decode(input logic [4:0] a, input logic [4:0] r,
                                        input logic pg);
        ldr_decode = pg && (a == r);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // link status synchroniser
    always_ff @(posedge clk_in) begin
        link_meta_reg <= link_in;
        link_sync_reg <= link_meta_reg;
        // hold stage for the whole-word agreement check
        link_hold_reg <= link_sync_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // drift sampler
    ldr_drift_sampler u_sampler (
        .clk_in     (clk_in),
        .srst_in    (srst_in),
        .trigger_in (trigger_reg),
        .choice_in  (choice_reg),
        .dsp_in     (dsp_in),
        .value_out  (drift_value),
        .busy_out   (sampler_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // page selection, choice and capture strobe
    assign diag_page = (page_reg == LDR_PAGE_DIAG);

    always_comb begin
        page_next    = page_reg;
        choice_next  = choice_reg;
        trigger_next = 1'b0;
        // read-only and reserved bits fall through
        if (req_in.wr) begin
            if (req_in.addr == LDR_PAGE_SEL_ADDR) begin
                page_next = req_in.wdata[1:0];
            end
            if (ldr_decode(req_in.addr, LDR_DRIFT_ADDR, diag_page)) begin
                choice_next  = req_in.wdata[LDR_CHOICE_BIT];
                trigger_next = req_in.wdata[LDR_TRIGGER_BIT];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            page_reg    <= LDR_PAGE_RESET;
            choice_reg  <= 1'b0;
            trigger_reg <= 1'b0;
        end else begin
            page_reg    <= page_next;
            choice_reg  <= choice_next;
            trigger_reg <= trigger_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wire length estimate
    // status word taken only when two synced samples agree
    assign link_stable = (link_sync_reg == link_hold_reg);

    always_comb begin
        length_next = length_reg;
        if (link_stable) begin
            // estimate valid only at 100 Mb/s with link and a determined length
            if (link_sync_reg.speed_100 && link_sync_reg.link_up
                && link_sync_reg.length_ok) begin
                length_next = link_sync_reg.length_m;
            end else begin
                length_next = LDR_LEN_UNKNOWN;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            length_reg <= LDR_BYTE_RESET;
        end else begin
            length_reg <= length_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port
    always_comb begin
        rdata_next  = LDR_WORD_RESET;
        rvalid_next = req_in.rd;
        hit_next    = 1'b0;
        // unmapped or off-page reads answer zero with no hit
        if (req_in.rd) begin
            if (req_in.addr == LDR_PAGE_SEL_ADDR) begin
                rdata_next = {14'h0000, page_reg};
                hit_next   = 1'b1;
            end else if (ldr_decode(req_in.addr, LDR_WIRE_LEN_ADDR, diag_page)) begin
                rdata_next = {8'h00, length_reg};
                hit_next   = 1'b1;
            end else if (ldr_decode(req_in.addr, LDR_DRIFT_ADDR, diag_page)) begin
                // trigger reads zero, signed drift byte in low bits
                rdata_next = {7'h00, choice_reg, drift_value};
                hit_next   = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_reg  <= LDR_WORD_RESET;
            rvalid_reg <= 1'b0;
            hit_reg    <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            hit_reg    <= hit_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capture status
    // strobe cycle counted too, before the sampler leaves idle
    assign busy_next = sampler_busy | trigger_reg;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= busy_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // layout checks: read word is built from fixed field positions
    if (LDR_TRIGGER_BIT != 15) begin : g_trigger_check
        $error("capture strobe must be the top bit of the word");
    end
    if (LDR_CHOICE_BIT != LDR_VALUE_MSB + 1) begin : g_choice_check
        $error("choice bit must sit just above the drift byte");
    end
    if (LDR_WIRE_LEN_ADDR == LDR_DRIFT_ADDR) begin : g_addr_check
        $error("diagnostic registers need distinct offsets");
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all registered
    assign rdata_out        = rdata_reg;
    assign rvalid_out       = rvalid_reg;
    assign hit_out          = hit_reg;
    assign capture_busy_out = busy_reg;
endmodule

// [verilog/ldr_pkg.sv]
/*
 * ldr_pkg: register map, field layout, reset values and carrier types of the
 * page-2 link diagnostic register bank.
 * assumes: register access arrives as a decoded word request from the serial
 * management front end, on the transceiver core clock.
 */
package ldr_pkg;
    // page selection
    localparam logic [4:0]  LDR_PAGE_SEL_ADDR  = 5'h13;
    localparam logic [1:0]  LDR_PAGE_DIAG      = 2'h2;
    // register offsets
    localparam logic [4:0]  LDR_WIRE_LEN_ADDR  = 5'h14;
    localparam logic [4:0]  LDR_DRIFT_ADDR     = 5'h15;
    // drift register fields
    localparam int          LDR_TRIGGER_BIT    = 15;
    localparam int          LDR_CHOICE_BIT     = 8;
    localparam int          LDR_VALUE_MSB      = 7;
    // codes and reset values
    localparam logic [7:0]  LDR_LEN_UNKNOWN    = 8'hFF;
    localparam logic [7:0]  LDR_BYTE_RESET     = 8'h00;
    localparam logic [15:0] LDR_WORD_RESET     = 16'h0000;
    localparam logic [1:0]  LDR_PAGE_RESET     = 2'h0;
    // drift step in units of 0.0001 ppm
    localparam int          LDR_DRIFT_STEP_E4  = 51562;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } ldr_req_type;

    typedef struct packed {
        logic        speed_100;
        logic        link_up;
        logic [7:0]  length_m;
        logic        length_ok;
    } ldr_link_type;

    typedef struct packed {
        logic        valid;
        logic [7:0]  offset;
        logic [7:0]  phase_corr;
    } ldr_dsp_type;
endpackage

// [verilog/ldr_drift_sampler.sv]
/*
 * ldr_drift_sampler: fetches the long-term offset or the frequency control
 * value from the signal processor on a capture strobe, holds the result.
 * assumes: dsp values are on the core clock and stable while valid is high.
 */
`timescale 1ns/1ps
module ldr_drift_sampler (
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 srst_in,
    // request
    input  wire logic                 trigger_in,
    input  wire logic                 choice_in,
    input  wire ldr_pkg::ldr_dsp_type dsp_in,
    // result
    output logic [7:0]                value_out,
    output logic                      busy_out
);
    import ldr_pkg::*;

    typedef enum logic [0:0] {LDR_IDLE, LDR_FETCH} ldr_state_type;

    ldr_state_type state_reg;
    ldr_state_type state_next;
    logic          choice_reg;
    logic          choice_next;
    logic [7:0]    value_reg;
    logic [7:0]    value_next;

    function automatic logic [7:0] ldr_control_value(input logic [7:0] off,
                                                     input logic [7:0] corr);
        ldr_control_value = 8'(off + corr);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next  = state_reg;
        choice_next = choice_reg;
        value_next  = value_reg;
        unique case (state_reg)
            LDR_IDLE: begin
                if (trigger_in) begin
                    choice_next = choice_in;
                    state_next  = LDR_FETCH;
                end
            end
            LDR_FETCH: begin
                if (dsp_in.valid) begin
                    if (choice_reg) begin
                        value_next = ldr_control_value(dsp_in.offset,
                                                       dsp_in.phase_corr);
                    end else begin
                        value_next = dsp_in.offset;
                    end
                    state_next = LDR_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg  <= LDR_IDLE;
            choice_reg <= 1'b0;
            value_reg  <= LDR_BYTE_RESET;
        end else begin
            state_reg  <= state_next;
            choice_reg <= choice_next;
            value_reg  <= value_next;
        end
    end

    assign value_out = value_reg;
    assign busy_out  = (state_reg == LDR_FETCH);
endmodule

// [dv/ldr_regs_monitor.sv]
/* ldr_regs_monitor: port checks of the page-2 diagnostic bank.
   assumes: bound to ldr_regs, one clock, sync reset. */
`timescale 1ns/1ps
module ldr_regs_monitor (
    // clock, access
    input wire logic                  clk_in,
    input wire logic                  srst_in,
    input wire ldr_pkg::ldr_req_type  req_in,
    input wire logic [15:0]           rdata_out,
    input wire logic                  rvalid_out,
    input wire logic                  hit_out,
    // status
    input wire ldr_pkg::ldr_link_type link_in,
    input wire ldr_pkg::ldr_dsp_type  dsp_in,
    input wire logic                  capture_busy_out
);
    import ldr_pkg::*;
    logic [1:0] pg_reg;
    always_ff @(posedge clk_in) begin
        if (srst_in) pg_reg <= 2'h0;
        else if (req_in.wr && req_in.addr == 5'h13) pg_reg <= req_in.wdata[1:0];
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence rd_diag_s;
        req_in.rd && req_in.addr inside {5'h14, 5'h15};
    endsequence
    sequence trig_s;
        req_in.wr && req_in.addr == 5'h15 && req_in.wdata[15] && pg_reg == 2'h2
            && !capture_busy_out;
    endsequence
    page_gate_a: assert property (rd_diag_s |=> hit_out == ($past(pg_reg) == 2'h2))
        else $error("page gate wrong");
    read_answer_a: assert property (req_in.rd |=> rvalid_out)
        else $error("read not answered");
    miss_zero_a: assert property (!hit_out |-> rdata_out == 16'h0000)
        else $error("refused read not zero");
    len_upper_a: assert property (rvalid_out && $past(req_in.addr) == 5'h14
        |-> rdata_out[15:8] == 8'h00) else $error("length upper bits set");
    drift_upper_a: assert property (rvalid_out && $past(req_in.addr) == 5'h15
        |-> rdata_out[15:9] == 7'h00) else $error("drift upper bits set");
    capture_start_a: assert property (trig_s |-> ##2 capture_busy_out)
        else $error("capture not started");
    capture_land_a: assert property (capture_busy_out && dsp_in.valid
        |-> ##2 !capture_busy_out) else $error("capture not landed");
    busy_cause_a: assert property ($rose(capture_busy_out) |->
        $past(req_in.wr, 2) && $past(req_in.addr, 2) == 5'h15)
        else $error("capture without trigger");
    reset_clear_a: assert property (disable iff (1'b0)
        srst_in |=> !rvalid_out && !hit_out && !capture_busy_out && rdata_out == 16'h0000)
        else $error("reset not clear");
endmodule
bind ldr_regs ldr_regs_monitor u_mon (.clk_in(clk_in), .srst_in(srst_in), .req_in(req_in),
    .rdata_out(rdata_out), .rvalid_out(rvalid_out), .hit_out(hit_out), .link_in(link_in),
    .dsp_in(dsp_in), .capture_busy_out(capture_busy_out));

// [dv/ldr_host_model.sv]
/* ldr_host_model: management host issuing word requests.
   assumes: answer one cycle after the read strobe. */
`timescale 1ns/1ps
module ldr_host_model (
    input  wire logic                 clk_in,
    input  wire logic [15:0]          rdata_in,
    input  wire logic                 hit_in,
    output ldr_pkg::ldr_req_type      req_out
);
    import ldr_pkg::*;
    initial req_out = '0;
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_in);
        #1 req_out = '{1'b0, 1'b1, a, d};
        @(posedge clk_in);
        #1 req_out = '0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic h);
        @(posedge clk_in);
        #1 req_out = '{1'b1, 1'b0, a, 16'h0000};
        @(posedge clk_in);
        #1 req_out = '0;
        d = rdata_in;
        h = hit_in;
    endtask
    task automatic sel_page(input logic [1:0] p);
        wr(5'h13, {14'h0000, p});
    endtask
endmodule

// [dv/ldr_regs_bench.sv]
/* ldr_regs_bench: self-checking bench of the diagnostic bank.
   assumes: host model drives requests; bench drives link and dsp. */
`timescale 1ns/1ps
module ldr_regs_bench;
    import ldr_pkg::*;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    ldr_req_type req;
    ldr_link_type link = '0;
    ldr_dsp_type dsp = '0;
    logic [15:0] rdata, d;
    logic rvalid, hit, busy, h;
    int n_errors = 0;
    int n_tests = 0;
    initial forever #5 clk_in = ~clk_in;
    ldr_host_model u_host (.clk_in(clk_in), .rdata_in(rdata), .hit_in(hit), .req_out(req));
    ldr_regs u_dut (.clk_in(clk_in), .srst_in(srst_in), .req_in(req), .rdata_out(rdata),
        .rvalid_out(rvalid), .hit_out(hit), .link_in(link), .dsp_in(dsp),
        .capture_busy_out(busy));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [15:0] e, input logic eh);
        u_host.rd(a, d, h);
        check(d, e);
        check({15'h0000, h}, {15'h0000, eh});
    endtask
    task automatic wait_idle;
        int i;
        repeat (2) @(posedge clk_in);
        #1;
        for (i = 0; i < 50 && busy !== 1'b0; i++) begin
            @(posedge clk_in);
            #1;
        end
        check({15'h0000, busy}, 16'h0000);
    endtask
    ////////////////////////////////////////
    task automatic t_page;
        rdchk(5'h13, 16'h0000, 1'b1);
        rdchk(5'h14, 16'h0000, 1'b0);
        u_host.wr(5'h15, 16'h8100);
        u_host.wr(5'h13, 16'hFFFE);
        rdchk(5'h13, 16'h0002, 1'b1);
        rdchk(5'h15, 16'h0000, 1'b1);
        rdchk(5'h14, 16'h00FF, 1'b1);
        rdchk(5'h1F, 16'h0000, 1'b0);
        $display("page test done");
    endtask
    task automatic t_len;
        link = '{1'b1, 1'b1, 8'h37, 1'b1};
        repeat (5) @(posedge clk_in);
        rdchk(5'h14, 16'h0037, 1'b1);
        u_host.wr(5'h14, 16'hFFFF);
        rdchk(5'h14, 16'h0037, 1'b1);
        link.link_up = 1'b0;
        repeat (5) @(posedge clk_in);
        rdchk(5'h14, 16'h00FF, 1'b1);
        $display("length test done");
    endtask
    task automatic t_drift;
        dsp = '{1'b0, 8'h7F, 8'h05};
        u_host.wr(5'h15, 16'h8000);
        repeat (4) @(posedge clk_in);
        #1 check({15'h0000, busy}, 16'h0001);
        dsp.valid = 1'b1;
        wait_idle();
        rdchk(5'h15, 16'h007F, 1'b1);
        dsp = '{1'b1, 8'h80, 8'hFE};
        u_host.wr(5'h15, 16'h8100);
        wait_idle();
        rdchk(5'h15, 16'h017E, 1'b1);
        u_host.wr(5'h15, 16'h7E00);
        dsp.offset = 8'h11;
        repeat (4) @(posedge clk_in);
        rdchk(5'h15, 16'h007E, 1'b1);
        $display("drift test done");
    endtask
    task automatic t_reset;
        srst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1 srst_in = 1'b0;
        rdchk(5'h13, 16'h0000, 1'b1);
        u_host.sel_page(2'h2);
        rdchk(5'h15, 16'h0000, 1'b1);
        $display("reset test done");
    endtask
    task automatic report_and_stop;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        #1 srst_in = 1'b0;
        t_page();
        t_len();
        t_drift();
        t_reset();
        report_and_stop();
    end
    initial begin
        #50000;
        n_errors++;
        report_and_stop();
    end
endmodule
